// ===== hw/apc_input_decode.sv
// Purpose: Decode of converter input selection code
// Assumes: Internal-source bit and 5-bit code from the input register
// Notes:   Prohibited codes report a bad source
`timescale 1ns/1ps
module apc_input_decode (
   input  wire logic            int_src,
   input  wire logic [4:0]      code,
   output apc_pkg::apc_src_t    src,
   output logic      [4:0]      pin_index
);
   always_comb begin
      src       = apc_pkg::APC_SRC_BAD;
      pin_index = 5'h00;
      if (int_src) begin
         if (code == 5'h00)
            src = apc_pkg::APC_SRC_TEMP;
         else if (code == 5'h01)
            src = apc_pkg::APC_SRC_VREF;
      end else if (code <= 5'h07 || (code >= 5'h10 && code <= 5'h18)) begin
         src       = apc_pkg::APC_SRC_PIN;
         pin_index = code;
      end else if (code == 5'h19) begin
         src = apc_pkg::APC_SRC_AMP;
      end
   end
endmodule

// ===== hw/apc_pkg.sv
// Purpose: Constants and types for the analogue front-end control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
package apc_pkg;
   localparam logic [7:0] ADDR_REF_CHECK = 8'h00;
   localparam logic [7:0] ADDR_UPPER     = 8'h04;
   localparam logic [7:0] ADDR_LOWER     = 8'h08;
   localparam logic [7:0] ADDR_INPUT     = 8'h0C;
   localparam logic [7:0] ADDR_PCLK_EN   = 8'h10;
   localparam logic [7:0] ADDR_CMP_MODE  = 8'h14;
   localparam logic [7:0] ADDR_AMP       = 8'h18;
   localparam logic [7:0] ADDR_CMP0_REF  = 8'h1C;
   localparam logic [7:0] ADDR_CMP1_REF  = 8'h20;
   localparam logic [7:0] ADDR_REFGEN    = 8'h24;
   localparam logic [7:0] ADDR_CONV_MODE = 8'h28;
   localparam logic [7:0] ADDR_STATUS    = 8'h2C;

   localparam int POS_REF_LSB   = 6;
   localparam int NEG_REF_BIT   = 5;
   localparam int WIN_CHECK_BIT = 3;
   localparam int WAKEUP_BIT    = 2;
   localparam int RES_BIT       = 0;
   localparam int INT_SRC_BIT   = 7;
   localparam int CLK_EN_BIT    = 5;
   localparam int CMP1_EN_BIT   = 4;
   localparam int CMP0_EN_BIT   = 0;
   localparam int CMP1_MON_BIT  = 7;
   localparam int CMP0_MON_BIT  = 3;
   localparam int AMP_EN_BIT    = 7;
   localparam int FB_GND_BIT    = 3;
   localparam int GEN1_EN_BIT   = 5;
   localparam int GEN_GND_BIT   = 4;
   localparam int GEN0_EN_BIT   = 2;
   localparam int GEN_SUP_BIT   = 1;
   localparam int ONESHOT_BIT   = 5;

   localparam logic [7:0] RST_REF_CHECK = 8'h00;
   localparam logic [7:0] RST_UPPER     = 8'hFF;
   localparam logic [7:0] RST_LOWER     = 8'h00;
   localparam logic [7:0] RST_INPUT     = 8'h00;
   localparam logic [7:0] RST_ZERO      = 8'h00;

   localparam logic [7:0] MASK_REF_CHECK = 8'hED;
   localparam logic [7:0] MASK_INPUT     = 8'h9F;
   localparam logic [7:0] MASK_CMP_MODE  = 8'h11;
   localparam logic [7:0] MASK_AMP       = 8'h8B;
   localparam logic [7:0] MASK_REFGEN    = 8'h36;
   localparam logic [7:0] MASK_CONV_MODE = 8'h20;
   localparam logic [7:0] MASK_PCLK      = 8'h20;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      APC_PREF_SUPPLY = 2'h0,
      APC_PREF_PIN    = 2'h1,
      APC_PREF_INT    = 2'h2,
      APC_PREF_BAD    = 2'h3
   } apc_pref_t;

   typedef enum logic [2:0] {
      APC_SRC_PIN  = 3'h1,
      APC_SRC_AMP  = 3'h2,
      APC_SRC_TEMP = 3'h3,
      APC_SRC_VREF = 3'h4,
      APC_SRC_BAD  = 3'h0
   } apc_src_t;

   typedef struct packed {
      apc_pref_t  pos_ref;
      logic       neg_ref_pin;
      logic       res_8bit;
      logic       oneshot;
      apc_src_t   src;
      logic [4:0] pin_index;
   } apc_conv_cfg_t;

   typedef struct packed {
      logic       clk_en;
      logic       cmp0_en;
      logic       cmp1_en;
      logic       amp_en;
      logic       fb_gnd_pin;
      logic [5:0] gain;
      logic [7:0] cmp0_code;
      logic [7:0] cmp1_code;
      logic       gen0_en;
      logic       gen1_en;
      logic       gen_gnd_pin;
      logic       gen_sup_pin;
   } apc_ana_cfg_t;
endpackage

// ===== hw/apc_top.sv
// Purpose: Register file and control for converter, amplifier, comparators
// Assumes: AXI4-Lite slave, synchronous active-high reset
// Notes:   Software must avoid prohibited selections; they are flagged only
`timescale 1ns/1ps
module apc_top (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic [7:0]           s_awaddr,
   input  wire logic                 s_awvalid,
   output logic                      s_awready,
   input  wire logic [31:0]          s_wdata,
   input  wire logic [3:0]           s_wstrb,
   input  wire logic                 s_wvalid,
   output logic                      s_wready,
   output logic [1:0]                s_bresp,
   output logic                      s_bvalid,
   input  wire logic                 s_bready,
   input  wire logic [7:0]           s_araddr,
   input  wire logic                 s_arvalid,
   output logic                      s_arready,
   output logic [31:0]               s_rdata,
   output logic [1:0]                s_rresp,
   output logic                      s_rvalid,
   input  wire logic                 s_rready,
   input  wire logic                 conv_done,
   input  wire logic [9:0]           conv_result,
   input  wire logic                 cmp0_out,
   input  wire logic                 cmp1_out,
   output logic                      conversion_end_irq,
   output apc_pkg::apc_conv_cfg_t    conv_cfg,
   output apc_pkg::apc_ana_cfg_t     ana_cfg,
   output logic                      amp_cmp_clock_en,
   output logic                      select_prohibited
);
   logic [7:0] ref_check_q;
   logic [7:0] upper_q;
   logic [7:0] lower_q;
   logic [7:0] input_q;
   logic [7:0] pclk_q;
   logic [7:0] cmp_mode_q;
   logic [7:0] amp_q;
   logic [7:0] cmp0_ref_q;
   logic [7:0] cmp1_ref_q;
   logic [7:0] refgen_q;
   logic [7:0] conv_mode_q;
   logic [9:0] last_result_q;
   logic       cmp0_mon_q;
   logic       cmp1_mon_q;

   logic       aw_held_q;
   logic [7:0] aw_addr_q;
   logic       w_held_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic       do_write;
   logic       wr_hit;
   logic       rd_hit;
   logic [7:0] rd_byte;

   apc_pkg::apc_src_t src;
   logic [4:0]        pin_index;
   logic              win_pass;

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a[1:0] == 2'b00) && (a <= apc_pkg::ADDR_STATUS);
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic       en,
                                        input logic [7:0] mask);
      merge = en ? (nw & mask) : old;
   endfunction

   // Write address and data taken independently
   always_ff @(posedge clock) begin
      if (rst) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (s_awvalid && s_awready) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= s_awaddr;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         w_held_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (s_wvalid && s_wready) begin
         w_held_q <= 1'b1;
         w_data_q <= s_wdata;
         w_strb_q <= s_wstrb;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   assign do_write = aw_held_q && w_held_q && !s_bvalid;
   assign wr_hit   = known_addr(aw_addr_q)
                     && aw_addr_q != apc_pkg::ADDR_STATUS;

   always_ff @(posedge clock) begin
      if (rst) begin
         s_awready <= 1'b1;
         s_wready  <= 1'b1;
      end else begin
         if (s_awvalid && s_awready)
            s_awready <= 1'b0;
         else if (do_write)
            s_awready <= 1'b1;
         if (s_wvalid && s_wready)
            s_wready <= 1'b0;
         else if (do_write)
            s_wready <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_bvalid <= 1'b0;
         s_bresp  <= apc_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_bvalid <= 1'b1;
         s_bresp  <= wr_hit ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // Register writes; only byte lane 0 carries data
   always_ff @(posedge clock) begin
      if (rst) begin
         ref_check_q <= apc_pkg::RST_REF_CHECK;
         upper_q     <= apc_pkg::RST_UPPER;
         lower_q     <= apc_pkg::RST_LOWER;
         input_q     <= apc_pkg::RST_INPUT;
         pclk_q      <= apc_pkg::RST_ZERO;
         cmp_mode_q  <= apc_pkg::RST_ZERO;
         amp_q       <= apc_pkg::RST_ZERO;
         cmp0_ref_q  <= apc_pkg::RST_ZERO;
         cmp1_ref_q  <= apc_pkg::RST_ZERO;
         refgen_q    <= apc_pkg::RST_ZERO;
         conv_mode_q <= apc_pkg::RST_ZERO;
      end else if (do_write && w_strb_q[0]) begin
         unique case (aw_addr_q)
            apc_pkg::ADDR_REF_CHECK: ref_check_q <= merge(ref_check_q,
               w_data_q[7:0], 1'b1, apc_pkg::MASK_REF_CHECK);
            apc_pkg::ADDR_UPPER:     upper_q <= w_data_q[7:0];
            apc_pkg::ADDR_LOWER:     lower_q <= w_data_q[7:0];
            apc_pkg::ADDR_INPUT:     input_q <= merge(input_q,
               w_data_q[7:0], 1'b1, apc_pkg::MASK_INPUT);
            apc_pkg::ADDR_PCLK_EN:   pclk_q <= merge(pclk_q,
               w_data_q[7:0], 1'b1, apc_pkg::MASK_PCLK);
            apc_pkg::ADDR_CMP_MODE:  cmp_mode_q <= merge(cmp_mode_q,
               w_data_q[7:0], 1'b1, apc_pkg::MASK_CMP_MODE);
            apc_pkg::ADDR_AMP:       amp_q <= merge(amp_q,
               w_data_q[7:0], 1'b1, apc_pkg::MASK_AMP);
            apc_pkg::ADDR_CMP0_REF:  cmp0_ref_q <= w_data_q[7:0];
            apc_pkg::ADDR_CMP1_REF:  cmp1_ref_q <= w_data_q[7:0];
            apc_pkg::ADDR_REFGEN:    refgen_q <= merge(refgen_q,
               w_data_q[7:0], 1'b1, apc_pkg::MASK_REFGEN);
            apc_pkg::ADDR_CONV_MODE: conv_mode_q <= merge(conv_mode_q,
               w_data_q[7:0], 1'b1, apc_pkg::MASK_CONV_MODE);
            default: ;
         endcase
      end
   end

   // Comparator monitors and last result, captured for readback
   always_ff @(posedge clock) begin
      if (rst) begin
         cmp0_mon_q    <= 1'b0;
         cmp1_mon_q    <= 1'b0;
         last_result_q <= 10'h000;
      end else begin
         cmp0_mon_q <= cmp0_out && cmp_mode_q[apc_pkg::CMP0_EN_BIT];
         cmp1_mon_q <= cmp1_out && cmp_mode_q[apc_pkg::CMP1_EN_BIT];
         if (conv_done)
            last_result_q <= conv_result;
      end
   end

   // Read path
   assign rd_hit = known_addr(s_araddr);

   always_comb begin
      unique case (s_araddr)
         apc_pkg::ADDR_REF_CHECK: rd_byte = ref_check_q;
         apc_pkg::ADDR_UPPER:     rd_byte = upper_q;
         apc_pkg::ADDR_LOWER:     rd_byte = lower_q;
         apc_pkg::ADDR_INPUT:     rd_byte = input_q;
         apc_pkg::ADDR_PCLK_EN:   rd_byte = pclk_q;
         apc_pkg::ADDR_CMP_MODE:  rd_byte = cmp_mode_q
            | ({7'h00, cmp1_mon_q} << apc_pkg::CMP1_MON_BIT)
            | ({7'h00, cmp0_mon_q} << apc_pkg::CMP0_MON_BIT);
         apc_pkg::ADDR_AMP:       rd_byte = amp_q;
         apc_pkg::ADDR_CMP0_REF:  rd_byte = cmp0_ref_q;
         apc_pkg::ADDR_CMP1_REF:  rd_byte = cmp1_ref_q;
         apc_pkg::ADDR_REFGEN:    rd_byte = refgen_q;
         apc_pkg::ADDR_CONV_MODE: rd_byte = conv_mode_q;
         apc_pkg::ADDR_STATUS:    rd_byte = last_result_q[9:2];
         default:                 rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_arready <= 1'b1;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= apc_pkg::RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b1;
         s_rdata   <= {24'h00_0000, rd_byte};
         s_rresp   <= rd_hit ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid  <= 1'b0;
         s_arready <= 1'b1;
      end
   end

   // Input decode and window check
   apc_input_decode u_dec (
      .int_src   (input_q[apc_pkg::INT_SRC_BIT]),
      .code      (input_q[4:0]),
      .src       (src),
      .pin_index (pin_index)
   );

   apc_window_check u_win (
      .window_sel (ref_check_q[apc_pkg::WIN_CHECK_BIT]),
      .res_8bit   (ref_check_q[apc_pkg::RES_BIT]),
      .result     (conv_result),
      .upper      (upper_q),
      .lower      (lower_q),
      .pass       (win_pass)
   );

   // Conversion-end pulse only when the window check passes
   always_ff @(posedge clock) begin
      if (rst)
         conversion_end_irq <= 1'b0;
      else
         conversion_end_irq <= conv_done && win_pass;
   end

   // Registered analogue configuration
   always_ff @(posedge clock) begin
      if (rst) begin
         conv_cfg          <= '0;
         ana_cfg           <= '0;
         amp_cmp_clock_en  <= 1'b0;
         select_prohibited <= 1'b0;
      end else begin
         conv_cfg.pos_ref     <= apc_pkg::apc_pref_t'(
            ref_check_q[apc_pkg::POS_REF_LSB +: 2]);
         conv_cfg.neg_ref_pin <= ref_check_q[apc_pkg::NEG_REF_BIT];
         conv_cfg.res_8bit    <= ref_check_q[apc_pkg::RES_BIT];
         conv_cfg.oneshot     <= conv_mode_q[apc_pkg::ONESHOT_BIT];
         conv_cfg.src         <= src;
         conv_cfg.pin_index   <= pin_index;
         amp_cmp_clock_en     <= pclk_q[apc_pkg::CLK_EN_BIT];
         ana_cfg.clk_en       <= pclk_q[apc_pkg::CLK_EN_BIT];
         ana_cfg.cmp0_en      <= cmp_mode_q[apc_pkg::CMP0_EN_BIT];
         ana_cfg.cmp1_en      <= cmp_mode_q[apc_pkg::CMP1_EN_BIT];
         ana_cfg.amp_en       <= amp_q[apc_pkg::AMP_EN_BIT];
         ana_cfg.fb_gnd_pin   <= amp_q[apc_pkg::FB_GND_BIT];
         ana_cfg.gain         <= 6'd4 << amp_q[1:0];
         ana_cfg.cmp0_code    <= cmp0_ref_q;
         ana_cfg.cmp1_code    <= cmp1_ref_q;
         ana_cfg.gen1_en      <= refgen_q[apc_pkg::GEN1_EN_BIT];
         ana_cfg.gen_gnd_pin  <= refgen_q[apc_pkg::GEN_GND_BIT];
         ana_cfg.gen0_en      <= refgen_q[apc_pkg::GEN0_EN_BIT];
         ana_cfg.gen_sup_pin  <= refgen_q[apc_pkg::GEN_SUP_BIT];
         select_prohibited    <= (src == apc_pkg::APC_SRC_BAD)
            || (ref_check_q[apc_pkg::POS_REF_LSB +: 2] == 2'h3);
      end
   end
endmodule

// ===== hw/apc_window_check.sv
// Purpose: Result window check gating the conversion-end interrupt
// Assumes: Result and limits compared on their upper 8 bits
// Notes:   8-bit results compared directly
`timescale 1ns/1ps
module apc_window_check (
   input  wire logic       window_sel,
   input  wire logic       res_8bit,
   input  wire logic [9:0] result,
   input  wire logic [7:0] upper,
   input  wire logic [7:0] lower,
   output logic            pass
);
   logic [7:0] r8;
   always_comb begin
      r8 = res_8bit ? result[7:0] : result[9:2];
      if (window_sel)
         pass = (r8 < lower) || (upper < r8);
      else
         pass = (lower <= r8);
   end
endmodule

// ===== tb/apc_asserts.sv
// Purpose: Port checks for the front-end control block
// Assumes: One clock, sync active-high reset
// Notes:   Config checks key on an OKAY write response
`timescale 1ns/1ps
module apc_asserts (
   input wire logic                   clock,
   input wire logic                   rst,
   input wire logic [7:0]             s_awaddr,
   input wire logic                   s_awvalid,
   input wire logic                   s_awready,
   input wire logic [31:0]            s_wdata,
   input wire logic [3:0]             s_wstrb,
   input wire logic                   s_wvalid,
   input wire logic                   s_wready,
   input wire logic [1:0]             s_bresp,
   input wire logic                   s_bvalid,
   input wire logic                   conv_done,
   input wire logic                   conversion_end_irq,
   input wire apc_pkg::apc_conv_cfg_t conv_cfg,
   input wire apc_pkg::apc_ana_cfg_t  ana_cfg,
   input wire logic                   amp_cmp_clock_en
);
   logic [7:0] wa_q;
   logic [7:0] wd_q;
   logic       ws_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Address of the write under way
   always_ff @(posedge clock) begin
      if (rst) begin
         wa_q <= 8'h00;
      end else if (s_awvalid && s_awready) begin
         wa_q <= s_awaddr;
      end
   end

   // Low data byte and lane strobe of the write under way
   always_ff @(posedge clock) begin
      if (rst) begin
         wd_q <= 8'h00;
         ws_q <= 1'b0;
      end else if (s_wvalid && s_wready) begin
         wd_q <= s_wdata[7:0];
         ws_q <= s_wstrb[0];
      end
   end

   sequence wr_seen(a);
      $rose(s_bvalid) && s_bresp == apc_pkg::RESP_OKAY && ws_q && wa_q == a;
   endsequence

   property cfg_follow(a, ok);
      wr_seen(a) |-> ##[0:2] ok;
   endproperty

   pos_ref_a: assert property (cfg_follow(apc_pkg::ADDR_REF_CHECK,
      conv_cfg.pos_ref == wd_q[7:6])) else $error("pos ref");
   neg_ref_a: assert property (cfg_follow(apc_pkg::ADDR_REF_CHECK,
      conv_cfg.neg_ref_pin == wd_q[5])) else $error("neg ref");
   res_sel_a: assert property (cfg_follow(apc_pkg::ADDR_REF_CHECK,
      conv_cfg.res_8bit == wd_q[0])) else $error("resolution");
   clk_gate_a: assert property (cfg_follow(apc_pkg::ADDR_PCLK_EN,
      amp_cmp_clock_en == wd_q[5] && ana_cfg.clk_en == wd_q[5]))
      else $error("clock gate");
   cmp_en_a: assert property (cfg_follow(apc_pkg::ADDR_CMP_MODE,
      ana_cfg.cmp0_en == wd_q[0] && ana_cfg.cmp1_en == wd_q[4]))
      else $error("cmp enable");
   amp_ctl_a: assert property (cfg_follow(apc_pkg::ADDR_AMP,
      ana_cfg.amp_en == wd_q[7] && ana_cfg.fb_gnd_pin == wd_q[3]))
      else $error("amp control");
   gain_code_a: assert property (cfg_follow(apc_pkg::ADDR_AMP,
      ana_cfg.gain == 6'h04 << wd_q[1:0])) else $error("gain");
   cmp0_code_a: assert property (cfg_follow(apc_pkg::ADDR_CMP0_REF,
      ana_cfg.cmp0_code == wd_q)) else $error("cmp0 code");
   cmp1_code_a: assert property (cfg_follow(apc_pkg::ADDR_CMP1_REF,
      ana_cfg.cmp1_code == wd_q)) else $error("cmp1 code");
   gen_en_a: assert property (cfg_follow(apc_pkg::ADDR_REFGEN,
      ana_cfg.gen1_en == wd_q[5] && ana_cfg.gen0_en == wd_q[2]))
      else $error("ref gen enable");
   gen_sel_a: assert property (cfg_follow(apc_pkg::ADDR_REFGEN,
      ana_cfg.gen_gnd_pin == wd_q[4] && ana_cfg.gen_sup_pin == wd_q[1]))
      else $error("ref gen select");
   oneshot_a: assert property (cfg_follow(apc_pkg::ADDR_CONV_MODE,
      conv_cfg.oneshot == wd_q[5])) else $error("oneshot");
   irq_cause_a: assert property (
      conversion_end_irq |-> $past(conv_done))
      else $error("irq without done");
endmodule

// ===== tb/apc_top_tb_top.sv
// Purpose: Self-checking bench for the front-end control block
// Assumes: Bench drives AXI4-Lite and converter inputs at rising edges
// Notes:   Read data and interrupts are checked from queues
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   bad_count++; $display("Error %s exp %h seen %h", nm, e, g); end end
module apc_top_tb_top;
   logic        clock, rst, s_awvalid, s_wvalid, s_bready, s_arvalid;
   logic        s_rready, conv_done, cmp0_out, cmp1_out, done_seen, exp_irq;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic        conversion_end_irq, amp_cmp_clock_en, select_prohibited;
   logic [7:0]  s_awaddr, s_araddr, lo_v, up_v, d8;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0]  s_wstrb;
   logic [1:0]  s_bresp, s_rresp;
   logic [9:0]  conv_result, r;
   logic [33:0] exp_rd;
   logic [33:0] rd_q[$];
   logic        irq_q[$];
   int          bad_count, check_count, cyc;
   apc_pkg::apc_conv_cfg_t conv_cfg;
   apc_pkg::apc_ana_cfg_t  ana_cfg;
   localparam logic [7:0] MSK [11] = '{apc_pkg::MASK_REF_CHECK, 8'hFF,
      8'hFF, apc_pkg::MASK_INPUT, apc_pkg::MASK_PCLK, apc_pkg::MASK_CMP_MODE,
      apc_pkg::MASK_AMP, 8'hFF, 8'hFF, apc_pkg::MASK_REFGEN,
      apc_pkg::MASK_CONV_MODE};
   localparam logic [9:0] BND [8] = '{10'h33F, 10'h340, 10'h380, 10'h381,
      10'h0FC, 10'h100, 10'h200, 10'h204};
   localparam logic [5:0] ICD [10] = '{6'h00, 6'h07, 6'h10, 6'h18, 6'h19,
      6'h20, 6'h21, 6'h08, 6'h1A, 6'h22};
   localparam logic [2:0] ISRC [10] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2,
      3'h3, 3'h4, 3'h0, 3'h0, 3'h0};

   apc_top dut (.clock, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
      .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
      .s_rready, .conv_done, .conv_result, .cmp0_out, .cmp1_out,
      .conversion_end_irq, .conv_cfg, .ana_cfg, .amp_cmp_clock_en,
      .select_prohibited);

   always #2 clock = ~clock;

   function automatic logic [33:0] okv(logic [7:0] v);
      return {apc_pkg::RESP_OKAY, 24'h0, v};
   endfunction

   function automatic logic win(logic sel, logic r8, logic [9:0] x);
      logic [7:0] v;
      v = r8 ? x[7:0] : x[9:2];
      return sel ? (v < lo_v || up_v < v) : (lo_v <= v);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] st, input logic [1:0] er);
      @(posedge clock);
      s_awaddr  <= a;
      s_wdata   <= {24'($urandom), d};
      s_wstrb   <= st;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      do begin
         @(posedge clock);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      s_bready <= 1'b0;
      `CHK("bresp", er, s_bresp)
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rd_q.push_back(e);
      @(posedge clock);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      do @(posedge clock); while (!s_arready);
      s_arvalid <= 1'b0;
      while (!s_rvalid) @(posedge clock);
      s_rready <= 1'b0;
   endtask

   task automatic conv(input logic [9:0] x, input logic e);
      irq_q.push_back(e);
      @(posedge clock);
      conv_done   <= 1'b1;
      conv_result <= x;
      @(posedge clock);
      conv_done   <= 1'b0;
      conv_result <= ~x;
   endtask

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      if (s_rvalid && s_rready) begin
         exp_rd = rd_q.pop_front();
         `CHK("read", exp_rd, {s_rresp, s_rdata})
      end
      if (done_seen) begin
         exp_irq = irq_q.pop_front();
         `CHK("irq", exp_irq, conversion_end_irq)
      end
      done_seen <= conv_done;
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         give_verdict();
      end
   end

   initial begin
      {clock, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {conv_done, cmp0_out, cmp1_out, done_seen} = '0;
      {s_awaddr, s_araddr, s_wdata, s_wstrb, conv_result} = '0;
      {bad_count, check_count, cyc} = '0;
      void'($urandom(32'h3d0c));
      rst = 1'b1;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 11; i++)
         rd(8'(i * 4), okv(i == 1 ? apc_pkg::RST_UPPER : 8'h00));
      `CHK("gain", 6'h04, ana_cfg.gain)
      for (int n = 0; n < 33; n++) begin
         d8 = 8'($urandom);
         wr(8'(n % 11 * 4), d8, 4'h1, apc_pkg::RESP_OKAY);
         rd(8'(n % 11 * 4), okv(d8 & MSK[n % 11]));
      end
      wr(apc_pkg::ADDR_UPPER, 8'h5A, 4'h1, apc_pkg::RESP_OKAY);
      wr(apc_pkg::ADDR_UPPER, 8'h12, 4'hE, apc_pkg::RESP_OKAY);
      rd(apc_pkg::ADDR_UPPER, okv(8'h5A));
      wr(8'h30, 8'h01, 4'h1, apc_pkg::RESP_SLVERR);
      wr(apc_pkg::ADDR_STATUS, 8'h01, 4'h1, apc_pkg::RESP_SLVERR);
      rd(8'h30, {apc_pkg::RESP_SLVERR, 32'h0});
      rd(8'h01, {apc_pkg::RESP_SLVERR, 32'h0});
      cmp0_out <= 1'b1;
      cmp1_out <= 1'b1;
      wr(apc_pkg::ADDR_CMP_MODE, 8'h11, 4'h1, apc_pkg::RESP_OKAY);
      rd(apc_pkg::ADDR_CMP_MODE, okv(8'h99));
      wr(apc_pkg::ADDR_CMP_MODE, 8'h01, 4'h1, apc_pkg::RESP_OKAY);
      rd(apc_pkg::ADDR_CMP_MODE, okv(8'h09));
      lo_v = 8'h40;
      up_v = 8'h80;
      wr(apc_pkg::ADDR_LOWER, lo_v, 4'h1, apc_pkg::RESP_OKAY);
      wr(apc_pkg::ADDR_UPPER, up_v, 4'h1, apc_pkg::RESP_OKAY);
      for (int m = 0; m < 4; m++) begin
         wr(apc_pkg::ADDR_REF_CHECK, 8'(8'h60 | m[1] << 3 | m[0]), 4'h1,
            apc_pkg::RESP_OKAY);
         for (int k = 0; k < 16; k++) begin
            r = k < 8 ? BND[k] : 10'($urandom);
            conv(r, win(m[1], m[0], r));
         end
      end
      rd(apc_pkg::ADDR_STATUS, okv(r[9:2]));
      // Each of ten input codes chosen with comparator generators stopped
      wr(apc_pkg::ADDR_REFGEN, 8'h00, 4'h1, apc_pkg::RESP_OKAY);
      for (int i = 9; i >= 0; i--) begin
         wr(apc_pkg::ADDR_INPUT, {ICD[i][5], 2'b00, ICD[i][4:0]}, 4'h1,
            apc_pkg::RESP_OKAY);
         repeat (2) @(posedge clock);
         `CHK("src", ISRC[i], conv_cfg.src)
         `CHK("bad sel", ISRC[i] == 3'h0, select_prohibited)
         if (ISRC[i] == 3'h1)
            `CHK("pin", ICD[i][4:0], conv_cfg.pin_index)
      end
      wr(apc_pkg::ADDR_REF_CHECK, 8'hC0, 4'h1, apc_pkg::RESP_OKAY);
      repeat (2) @(posedge clock);
      `CHK("bad ref", 1'b1, select_prohibited)
      wr(apc_pkg::ADDR_REF_CHECK, 8'h80, 4'h1, apc_pkg::RESP_OKAY);
      repeat (2) @(posedge clock);
      `CHK("good ref", 1'b0, select_prohibited)
      repeat (4) @(posedge clock);
      give_verdict();
   end
endmodule

bind apc_top apc_asserts chk (.clock, .rst, .s_awaddr, .s_awvalid,
   .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
   .s_bvalid, .conv_done, .conversion_end_irq, .conv_cfg, .ana_cfg,
   .amp_cmp_clock_en);
